// ---- rtl/sdp_pkg.sv ----
// Constants, register map and state types for the single-pin debug port.
// Assumes one 25 MHz system clock and an AXI4-Lite master for software access.
package sdp_pkg;
    // Register byte addresses
    localparam logic [7:0]  A_OPT        = 8'h00;
    localparam logic [7:0]  A_PERIOD     = 8'h04;
    localparam logic [7:0]  A_STAT       = 8'h08;
    localparam logic [7:0]  A_RTC        = 8'h0c;
    localparam logic [7:0]  A_CTRL       = 8'h10;
    localparam logic [1:0]  RESP_OK      = 2'h0;
    localparam logic [1:0]  RESP_DEC     = 2'h3;
    // Option byte, erased value
    localparam logic [7:0]  OPT_RESET    = 8'hff;
    localparam int          OPT_RP_BIT   = 2;
    // Control and status byte fields
    localparam int          CTL_DBG      = 7;
    localparam int          CTL_BRK      = 6;
    localparam int          CTL_ACK      = 5;
    // Command bytes
    localparam logic [7:0]  CMD_REV      = 8'h00;
    localparam logic [7:0]  CMD_RSVD     = 8'h01;
    localparam logic [7:0]  CMD_STAT     = 8'h02;
    localparam logic [7:0]  CMD_RTC      = 8'h03;
    localparam logic [7:0]  CMD_WCTL     = 8'h04;
    localparam logic [7:0]  CMD_RCTL     = 8'h05;
    localparam logic [7:0]  CMD_WPC      = 8'h06;
    localparam logic [7:0]  CMD_RPC      = 8'h07;
    localparam logic [7:0]  CMD_WREG     = 8'h08;
    localparam logic [7:0]  CMD_RREG     = 8'h09;
    localparam logic [7:0]  ACK_CHAR     = 8'hff;
    localparam logic [15:0] RTC_MAX      = 16'hffff;
    // Revision value is arbitrary
    localparam logic [15:0] REVISION     = 16'h0100;
    // Flash control register window, values arbitrary
    localparam logic [11:0] FLASH_LO     = 12'hff8;
    localparam logic [11:0] FLASH_HI     = 12'hffb;
    localparam logic [11:0] FLASH_CTRL   = 12'hff8;
    localparam logic [7:0]  MASS_ERASE   = 8'h63;
    // Bit timing: pin rate at most clock/4
    localparam int          CLK_HZ       = 25_000_000;
    localparam int          BAUD         = 115_200;
    localparam int          PIN_CLK_DIV  = 4;
    localparam logic [15:0] PERIOD_MIN   = 16'(PIN_CLK_DIV);
    localparam logic [15:0] PERIOD_RESET = 16'(CLK_HZ / BAUD);
    localparam logic [3:0]  FRAME_LAST   = 4'h9;

    typedef enum logic [2:0] {
        L_IDLE = 3'b001,
        L_RX   = 3'b010,
        L_TX   = 3'b100
    } sdp_link_e;

    typedef enum logic [3:0] {
        C_CMD   = 4'b0001,
        C_ARGS  = 4'b0010,
        C_FETCH = 4'b0100,
        C_REPLY = 4'b1000
    } sdp_cmd_e;

    typedef struct packed {
        sdp_link_e   lst;
        sdp_cmd_e    cst;
        logic        sync1;
        logic        sync2;
        logic        rx_prev;
        logic [15:0] timer;
        logic [3:0]  bitn;
        logic [9:0]  shreg;
        logic        pin_oe;
        logic [7:0]  cmd;
        logic [1:0]  argn;
        logic [23:0] args;
        logic [1:0]  replyn;
        logic [15:0] reply;
        logic        ack_pend;
        logic        dbg;
        logic        bp_en;
        logic        ack_en;
        logic [15:0] rtc;
        logic [7:0]  option;
        logic [15:0] period;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        pc_wr;
        logic [15:0] pc_wdata;
        logic        reg_wr;
        logic [11:0] reg_addr;
        logic [7:0]  reg_wdata;
    } sdp_state_s;
endpackage : sdp_pkg

// ---- rtl/sdp_debug_port.sv ----
// Single-pin debug unit: serial command decoder, runtime counter, AXI4-Lite registers.
// Assumes an external pull-up on the pin and a core that honours pc/reg strobes.
`timescale 1ns/1ps
// Behaviour
// - One open-drain pin carries both directions of the debug link.
// - Half duplex: no reception while the device transmits.
// - Characters use start bit, eight data bits LSB first, stop bit.
// - A watchpoint enters debug mode and sets the debug-mode flag.
// - Sixteen-bit runtime counter advances each clock outside debug mode.
// - Counter starts on debug exit, stops on re-entry or at all ones.
// - Host controls the unit only through received command bytes.
// - Outside debug mode only revision, status, control write and read run.
// - In debug mode all defined commands run except those refused under protection; code 01 is reserved.
// - Status and control reads work in any mode and under protection.
// - Under protection a control write cannot clear the debug-mode flag.
// - Under protection program counter reads/writes and register reads are refused.
// - Under protection register writes reach only flash control registers.
// - Under protection flash control accepts only the mass-erase value.
// - Option byte bit 2 low turns protection on; erased high is open.
// - With acknowledge enabled, a watchpoint or an enabled breakpoint sends FF to host.
// - Status byte MSB reads one in debug mode, zero otherwise.
module sdp_debug_port (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        debug_serial_pin_i,
    output logic             debug_serial_pin_o,
    output logic             debug_serial_pin_oe,
    input  wire logic        watchpoint_hit,
    input  wire logic        breakpoint_hit,
    output logic             debug_mode_flag,
    output logic             pc_wr,
    output logic [15:0]      pc_wdata,
    input  wire logic [15:0] pc_rdata,
    output logic             reg_wr,
    output logic [11:0]      reg_addr,
    output logic [7:0]       reg_wdata,
    input  wire logic [7:0]  reg_rdata
);
    sdp_pkg::sdp_state_s s;
    sdp_pkg::sdp_state_s n;
    logic        rp;
    logic        rx_done;
    logic [7:0]  rx_byte;
    logic        tx_go;
    logic [7:0]  tx_byte;
    logic        exec;
    logic [15:0] per;
    logic [7:0]  stat_byte;
    logic [7:0]  ctrl_byte;

    function automatic logic [1:0] argc(input logic [7:0] c);
        case (c)
            sdp_pkg::CMD_WCTL: argc = 2'h1;
            sdp_pkg::CMD_WPC:  argc = 2'h2;
            sdp_pkg::CMD_RREG: argc = 2'h2;
            sdp_pkg::CMD_WREG: argc = 2'h3;
            default:           argc = 2'h0;
        endcase
    endfunction : argc

    function automatic logic [1:0] repc(input logic [7:0] c);
        case (c)
            sdp_pkg::CMD_REV:  repc = 2'h2;
            sdp_pkg::CMD_RTC:  repc = 2'h2;
            sdp_pkg::CMD_RPC:  repc = 2'h2;
            sdp_pkg::CMD_STAT: repc = 2'h1;
            sdp_pkg::CMD_RCTL: repc = 2'h1;
            sdp_pkg::CMD_RREG: repc = 2'h1;
            default:           repc = 2'h0;
        endcase
    endfunction : repc

    function automatic logic allowed(input logic [7:0] c, input logic dm, input logic prot);
        if (!dm)
            allowed = (c == sdp_pkg::CMD_REV) || (c == sdp_pkg::CMD_STAT)
                   || (c == sdp_pkg::CMD_WCTL) || (c == sdp_pkg::CMD_RCTL);
        else
            allowed = (c != sdp_pkg::CMD_RSVD) && (c <= sdp_pkg::CMD_RREG)
                   && !(prot && ((c == sdp_pkg::CMD_WPC) || (c == sdp_pkg::CMD_RPC)
                   || (c == sdp_pkg::CMD_RREG)));
    endfunction : allowed

    assign rp = !s.option[sdp_pkg::OPT_RP_BIT];
    assign stat_byte = {s.dbg, 1'h0, rp, 5'h00};
    assign ctrl_byte = {s.dbg, s.bp_en, s.ack_en, 5'h00};
    assign rx_byte = s.shreg[9:2];

    always_comb
    begin
        n = s;
        rx_done = 1'h0;
        tx_go = 1'h0;
        tx_byte = 8'h00;
        exec = 1'h0;
        per = s.period;
        n.pc_wr = 1'h0;
        n.reg_wr = 1'h0;
        // Two-flop synchroniser, edge seen after it
        n.sync1 = debug_serial_pin_i;
        n.sync2 = s.sync1;
        n.rx_prev = s.sync2;

        unique case (s.lst)
            sdp_pkg::L_IDLE:
            begin
                if (s.rx_prev && !s.sync2)
                begin
                    n.lst = sdp_pkg::L_RX;
                    n.timer = {1'h0, s.period[15:1]};
                    n.bitn = 4'h0;
                end
            end
            sdp_pkg::L_RX:
            begin
                if (s.timer == 16'h0000)
                begin
                    n.timer = s.period;
                    n.bitn = s.bitn + 4'h1;
                    n.shreg = {s.sync2, s.shreg[9:1]};
                    // Glitch start or bad stop drops the frame
                    if (s.bitn == 4'h0 && s.sync2)
                        n.lst = sdp_pkg::L_IDLE;
                    else if (s.bitn == sdp_pkg::FRAME_LAST)
                    begin
                        n.lst = sdp_pkg::L_IDLE;
                        rx_done = s.sync2;
                    end
                end
                else
                    n.timer = s.timer - 16'h0001;
            end
            sdp_pkg::L_TX:
            begin
                if (s.timer != 16'h0000)
                    n.timer = s.timer - 16'h0001;
                else if (s.bitn == sdp_pkg::FRAME_LAST)
                    n.lst = sdp_pkg::L_IDLE;
                else
                begin
                    n.timer = s.period;
                    n.bitn = s.bitn + 4'h1;
                    n.shreg = {1'h1, s.shreg[9:1]};
                end
            end
        endcase

        unique case (s.cst)
            sdp_pkg::C_CMD:
            begin
                if (rx_done)
                begin
                    n.cmd = rx_byte;
                    n.argn = argc(rx_byte);
                    if (argc(rx_byte) == 2'h0)
                        exec = 1'h1;
                    else
                        n.cst = sdp_pkg::C_ARGS;
                end
            end
            sdp_pkg::C_ARGS:
            begin
                if (rx_done)
                begin
                    n.args = {s.args[15:0], rx_byte};
                    n.argn = s.argn - 2'h1;
                    exec = (s.argn == 2'h1);
                end
            end
            sdp_pkg::C_FETCH:
            begin
                n.reply = {reg_rdata, 8'h00};
                n.cst = sdp_pkg::C_REPLY;
            end
            sdp_pkg::C_REPLY:
            begin
                if (s.replyn == 2'h0)
                    n.cst = sdp_pkg::C_CMD;
            end
        endcase

        if (exec)
        begin
            // Refused commands reply with zeros only
            n.replyn = repc(n.cmd);
            n.reply = 16'h0000;
            n.cst = (repc(n.cmd) != 2'h0) ? sdp_pkg::C_REPLY : sdp_pkg::C_CMD;
            if (allowed(n.cmd, s.dbg, rp))
            begin
                case (n.cmd)
                    sdp_pkg::CMD_REV:  n.reply = sdp_pkg::REVISION;
                    sdp_pkg::CMD_STAT: n.reply = {stat_byte, 8'h00};
                    sdp_pkg::CMD_RCTL: n.reply = {ctrl_byte, 8'h00};
                    sdp_pkg::CMD_RTC:  n.reply = s.rtc;
                    sdp_pkg::CMD_RPC:  n.reply = pc_rdata;
                    sdp_pkg::CMD_WCTL:
                    begin
                        n.dbg = n.args[sdp_pkg::CTL_DBG] || (rp && s.dbg);
                        n.bp_en = n.args[sdp_pkg::CTL_BRK];
                        n.ack_en = n.args[sdp_pkg::CTL_ACK];
                    end
                    sdp_pkg::CMD_WPC:
                    begin
                        n.pc_wr = 1'h1;
                        n.pc_wdata = n.args[15:0];
                    end
                    sdp_pkg::CMD_WREG:
                    begin
                        n.reg_addr = n.args[19:8];
                        n.reg_wdata = n.args[7:0];
                        // Flash window and mass erase only
                        n.reg_wr = !rp || ((n.args[19:8] >= sdp_pkg::FLASH_LO)
                                && (n.args[19:8] <= sdp_pkg::FLASH_HI)
                                && ((n.args[19:8] != sdp_pkg::FLASH_CTRL)
                                || (n.args[7:0] == sdp_pkg::MASS_ERASE)));
                    end
                    sdp_pkg::CMD_RREG:
                    begin
                        n.reg_addr = n.args[11:0];
                        n.cst = sdp_pkg::C_FETCH;
                    end
                    default: n.reply = 16'h0000;
                endcase
            end
        end

        // Transmit only when the link is quiet
        if (s.lst == sdp_pkg::L_IDLE && n.lst == sdp_pkg::L_IDLE)
        begin
            if (s.cst == sdp_pkg::C_CMD && n.cst == sdp_pkg::C_CMD && s.ack_pend)
            begin
                tx_go = 1'h1;
                tx_byte = sdp_pkg::ACK_CHAR;
                n.ack_pend = 1'h0;
            end
            else if (s.cst == sdp_pkg::C_REPLY && s.replyn != 2'h0)
            begin
                tx_go = 1'h1;
                tx_byte = s.reply[15:8];
                n.reply = {s.reply[7:0], 8'h00};
                n.replyn = s.replyn - 2'h1;
            end
        end
        if (tx_go)
        begin
            // Start bit low, stop bit high
            n.lst = sdp_pkg::L_TX;
            n.shreg = {1'h1, tx_byte, 1'h0};
            n.bitn = 4'h0;
            n.timer = s.period;
        end
        // Pull low for zero, release for one
        n.pin_oe = (n.lst == sdp_pkg::L_TX) && !n.shreg[0];

        // Halt events win over a clearing write
        if (watchpoint_hit || (breakpoint_hit && s.bp_en))
        begin
            n.dbg = 1'h1;
            if (s.ack_en)
                n.ack_pend = 1'h1;
        end
        // Restart on exit, saturate at all ones
        if (s.dbg && !n.dbg)
            n.rtc = 16'h0000;
        else if (!s.dbg && s.rtc != sdp_pkg::RTC_MAX)
            n.rtc = s.rtc + 16'h0001;

        // Write channel: address and data in either order
        if (s.bvalid && s_axi_bready)
            n.bvalid = 1'h0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            n.aw_got = 1'h1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            n.w_got = 1'h1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.aw_got && s.w_got)
        begin
            n.aw_got = 1'h0;
            n.w_got = 1'h0;
            n.bvalid = 1'h1;
            n.bresp = sdp_pkg::RESP_OK;
            if (s.wstrb[0])
                per[7:0] = s.wdata[7:0];
            if (s.wstrb[1])
                per[15:8] = s.wdata[15:8];
            case (s.awaddr)
                sdp_pkg::A_OPT:
                begin
                    if (s.wstrb[0])
                        n.option = s.wdata[7:0];
                end
                // Clamped so the pin never beats clock/4
                sdp_pkg::A_PERIOD: n.period = (per < sdp_pkg::PERIOD_MIN)
                                              ? sdp_pkg::PERIOD_MIN : per;
                sdp_pkg::A_STAT, sdp_pkg::A_RTC, sdp_pkg::A_CTRL: n.bresp = sdp_pkg::RESP_OK;
                default: n.bresp = sdp_pkg::RESP_DEC;
            endcase
        end
        if (s.rvalid && s_axi_rready)
            n.rvalid = 1'h0;
        if (s_axi_arvalid && !s.rvalid)
        begin
            n.rvalid = 1'h1;
            n.rresp = sdp_pkg::RESP_OK;
            n.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                sdp_pkg::A_OPT:    n.rdata[7:0] = s.option;
                sdp_pkg::A_PERIOD: n.rdata[15:0] = s.period;
                sdp_pkg::A_STAT:   n.rdata[7:0] = stat_byte;
                sdp_pkg::A_RTC:    n.rdata[15:0] = s.rtc;
                sdp_pkg::A_CTRL:   n.rdata[7:0] = ctrl_byte;
                default:           n.rresp = sdp_pkg::RESP_DEC;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.lst <= sdp_pkg::L_IDLE;
            s.cst <= sdp_pkg::C_CMD;
            s.sync1 <= 1'h1;
            s.sync2 <= 1'h1;
            s.rx_prev <= 1'h1;
            s.option <= sdp_pkg::OPT_RESET;
            s.period <= sdp_pkg::PERIOD_RESET;
        end
        else
            s <= n;
    end

    assign s_axi_awready = !s.aw_got && !s.bvalid;
    assign s_axi_wready = !s.w_got && !s.bvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;
    assign debug_serial_pin_o = 1'h0;
    assign debug_serial_pin_oe = s.pin_oe;
    assign debug_mode_flag = s.dbg;
    assign pc_wr = s.pc_wr;
    assign pc_wdata = s.pc_wdata;
    assign reg_wr = s.reg_wr;
    assign reg_addr = s.reg_addr;
    assign reg_wdata = s.reg_wdata;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_tx_begin;
        s.lst == sdp_pkg::L_IDLE ##1 s.lst == sdp_pkg::L_TX;
    endsequence

    a_watch_entry: assert property (watchpoint_hit |=> s.dbg)
        else $error("watchpoint did not enter debug mode");
    a_rtc_count: assert property (!s.dbg && s.rtc != sdp_pkg::RTC_MAX
        |=> s.rtc == $past(s.rtc) + 16'h0001)
        else $error("runtime counter failed to advance");
    a_rtc_frozen: assert property (s.dbg |=> !s.dbg || $stable(s.rtc))
        else $error("runtime counter moved in debug mode");
    a_rtc_saturate: assert property (s.rtc == sdp_pkg::RTC_MAX && !s.dbg
        |=> s.rtc == sdp_pkg::RTC_MAX)
        else $error("runtime counter wrapped");
    a_protect_hold: assert property (rp && s.dbg |=> s.dbg)
        else $error("debug flag cleared under protection");
    a_pc_guard: assert property (s.pc_wr |-> !$past(rp) && $past(s.dbg))
        else $error("program counter write while refused");
    a_reg_window: assert property (s.reg_wr && $past(rp)
        |-> s.reg_addr >= sdp_pkg::FLASH_LO && s.reg_addr <= sdp_pkg::FLASH_HI)
        else $error("protected register write outside flash window");
    a_erase_only: assert property (s.reg_wr && $past(rp) && s.reg_addr == sdp_pkg::FLASH_CTRL
        |-> s.reg_wdata == sdp_pkg::MASS_ERASE)
        else $error("protected flash control write not mass erase");
    a_tx_start: assert property (s_tx_begin |-> s.pin_oe && s.bitn == 4'h0)
        else $error("frame did not open with start bit");
    a_quiet_link: assert property (s.lst != sdp_pkg::L_TX |-> !s.pin_oe)
        else $error("pin driven outside transmission");
    a_bresp_hold: assert property (s.bvalid && !s_axi_bready |=> s.bvalid && $stable(s.bresp))
        else $error("write response dropped early");
endmodule : sdp_debug_port

// ---- verification/sdp_host_model.sv ----
// Debug host model: frames bytes onto the shared pin and reads frames back.
// Assumes a pull-up on the pin and a bit time of bit_clks clocks.
`timescale 1ns/1ps
module sdp_host_model (
    input  wire logic aclk,
    input  wire logic pin,
    output logic      host_oe
);
    int bit_clks = 5;
    initial host_oe = 1'b0;
    // Open drain, start low, LSB first
    task automatic send(input logic [7:0] d);
        logic [8:0] f;
        f = {d, 1'b0};
        @(posedge aclk);
        for (int i = 0; i < 9; i++)
        begin
            host_oe <= ~f[i];
            repeat (bit_clks) @(posedge aclk);
        end
        // Stop bit is the pull-up itself
        host_oe <= 1'b0;
        @(posedge aclk);
    endtask : send
    // Listens only once its own frame is out
    task automatic recv(output logic [7:0] d, output logic ok);
        logic [9:0] f;
        int         n;
        n = 0;
        while (pin !== 1'b0 && n < 3000)
        begin
            @(negedge aclk);
            n++;
        end
        repeat (bit_clks / 2) @(negedge aclk);
        for (int i = 0; i < 10; i++)
        begin
            f[i] = pin;
            // No wait after stop: a second reply byte may follow at once
            if (i < 9) repeat (bit_clks) @(negedge aclk);
        end
        d = f[8:1];
        ok = (f[0] === 1'b0) && (f[9] === 1'b1) && (n < 3000);
    endtask : recv
endmodule : sdp_host_model

// ---- verification/tb_sdp_debug_port.sv ----
// Self-checking bench: AXI4-Lite register access plus host commands on the pin.
// Assumes bit period is set to 4, so one bit lasts 5 clocks.
`timescale 1ns/1ps
module tb_sdp_debug_port;
    logic        aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
    logic        arvalid = 1'b0, rready = 1'b1, wp = 1'b0, bp = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, host_oe;
    logic        dbg, pc_wr, reg_wr, pin;
    logic [1:0]  bresp, rresp;
    logic [3:0]  wstrb = 4'hf;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, reg_wdata;
    logic [11:0] reg_addr;
    logic [15:0] pc_wdata, last_pc;
    logic [19:0] last_reg;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    int          n_errors, checked, n_pc, n_reg, cyc;
    // Wired-AND with pull-up
    assign pin = !(pin_oe && !pin_o) && !host_oe;
    sdp_debug_port i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .debug_serial_pin_i(pin), .debug_serial_pin_o(pin_o),
        .debug_serial_pin_oe(pin_oe), .watchpoint_hit(wp), .breakpoint_hit(bp),
        .debug_mode_flag(dbg), .pc_wr(pc_wr), .pc_wdata(pc_wdata), .pc_rdata(16'h4321),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(8'h5a)
    );
    sdp_host_model i_host (.aclk(aclk), .pin(pin), .host_oe(host_oe));
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic close_out();
        $display("Errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    // Strobe monitor and hang limit
    always @(posedge aclk)
    begin
        cyc++;
        if (pc_wr === 1'b1) n_pc++;
        if (pc_wr === 1'b1) last_pc <= pc_wdata;
        if (reg_wr === 1'b1) n_reg++;
        if (reg_wr === 1'b1) last_reg <= {reg_addr, reg_wdata};
        if (cyc == 20000) n_errors++;
        if (cyc == 20000) close_out();
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) n_errors++;
        if (g !== e) $display("Error %s expected %h seen %h", nm, e, g);
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
        logic ta, tw, b;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            b = bvalid;
            s = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        while (!b);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
        logic ta, r;
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(negedge aclk);
            ta = arvalid && arready;
            r = rvalid;
            d = rdata;
            s = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        while (!r);
    endtask : axi_rd
    // Command byte, args MSB first, then reply bytes
    task automatic cmd(input logic [7:0] c, input int na, input logic [23:0] a, input int nr,
                       output logic [31:0] r);
        logic [7:0] d;
        logic       ok;
        r = 32'h0000_0000;
        i_host.send(c);
        for (int i = na - 1; i >= 0; i--)
        begin
            repeat (5) @(posedge aclk);
            i_host.send(a[8*i +: 8]);
        end
        for (int i = 0; i < nr; i++)
        begin
            i_host.recv(d, ok);
            r = {r[23:0], d};
            chk("frame", 32'h0000_0001, {31'h0, ok});
        end
        repeat (12) @(posedge aclk);
    endtask : cmd
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  s;
        axi_rd(sdp_pkg::A_OPT, d, s);
        chk("option", 32'h0000_00ff, d);
        axi_rd(8'h20, d, s);
        chk("unmapped", {30'h0, sdp_pkg::RESP_DEC}, {30'h0, s});
        axi_wr(sdp_pkg::A_PERIOD, 32'h0000_0004, s);
        chk("bresp", 32'h0000_0000, {30'h0, s});
    endtask : t_regs
    task automatic t_modes();
        logic [31:0] r, d1, d2;
        logic [7:0]  a;
        logic        ok;
        logic [1:0]  s;
        cmd(sdp_pkg::CMD_REV, 0, 24'h00_0000, 2, r);
        chk("revision", {16'h0, sdp_pkg::REVISION}, r);
        cmd(sdp_pkg::CMD_RTC, 0, 24'h00_0000, 2, r);
        chk("counter refused", 32'h0000_0000, r);
        cmd(sdp_pkg::CMD_STAT, 0, 24'h00_0000, 1, r);
        chk("status", 32'h0000_0000, r);
        cmd(sdp_pkg::CMD_WCTL, 1, 24'h00_0020, 0, r);
        wp <= 1'b1;
        @(posedge aclk);
        wp <= 1'b0;
        i_host.recv(a, ok);
        chk("ack", {24'h0, sdp_pkg::ACK_CHAR}, {24'h0, a});
        chk("flag", 32'h0000_0001, {31'h0, dbg});
        cmd(sdp_pkg::CMD_RCTL, 0, 24'h00_0000, 1, r);
        chk("control", 32'h0000_00a0, r);
        axi_rd(sdp_pkg::A_RTC, d1, s);
        repeat (20) @(posedge aclk);
        axi_rd(sdp_pkg::A_RTC, d2, s);
        chk("counter held", d1, d2);
        cmd(sdp_pkg::CMD_WPC, 2, 24'h00_1234, 0, r);
        chk("pc write", 32'h0001_1234, {n_pc[15:0], last_pc});
        cmd(sdp_pkg::CMD_RPC, 0, 24'h00_0000, 2, r);
        chk("pc read", 32'h0000_4321, r);
        cmd(sdp_pkg::CMD_RREG, 2, 24'h00_0123, 1, r);
        chk("reg read", 32'h0000_005a, r);
        chk("reg addr", 32'h0000_0123, {20'h0, reg_addr});
    endtask : t_modes
    task automatic t_protect();
        logic [31:0] r, d1, d2;
        logic [1:0]  s;
        axi_wr(sdp_pkg::A_OPT, 32'h0000_00fb, s);
        cmd(sdp_pkg::CMD_STAT, 0, 24'h00_0000, 1, r);
        chk("status", 32'h0000_00a0, r);
        cmd(sdp_pkg::CMD_WPC, 2, 24'h00_5555, 0, r);
        cmd(sdp_pkg::CMD_RPC, 0, 24'h00_0000, 2, r);
        chk("pc blocked", 32'h0001_0000, {n_pc[15:0], r[15:0]});
        cmd(sdp_pkg::CMD_WREG, 3, 24'h0f_f800, 0, r);
        cmd(sdp_pkg::CMD_WREG, 3, 24'h00_1063, 0, r);
        chk("reg blocked", 32'h0000_0000, n_reg);
        cmd(sdp_pkg::CMD_WREG, 3, 24'h0f_f863, 0, r);
        chk("erase", 32'h001f_f863, {n_reg[11:0], last_reg});
        cmd(sdp_pkg::CMD_WCTL, 1, 24'h00_0000, 0, r);
        chk("flag kept", 32'h0000_0001, {31'h0, dbg});
        axi_wr(sdp_pkg::A_OPT, 32'h0000_00ff, s);
        cmd(sdp_pkg::CMD_WCTL, 1, 24'h00_0000, 0, r);
        chk("flag clear", 32'h0000_0000, {31'h0, dbg});
        axi_rd(sdp_pkg::A_RTC, d1, s);
        repeat (20) @(posedge aclk);
        axi_rd(sdp_pkg::A_RTC, d2, s);
        chk("counter runs", 32'h0000_0001, {31'h0, d2 > d1 + 32'd20});
        for (int k = 0; k < 2; k++)
        begin
            cmd(sdp_pkg::CMD_WCTL, 1, {17'h0, k[0], 6'h0}, 0, r);
            bp <= 1'b1;
            @(posedge aclk);
            bp <= 1'b0;
            repeat (2) @(posedge aclk);
            chk("break", {31'h0, k[0]}, {31'h0, dbg});
        end
    endtask : t_protect
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_modes();
        t_protect();
        close_out();
    end
endmodule : tb_sdp_debug_port
